/* core/reset_and_stop_recovery_control.sv */
// Local design decision: the APB register port.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - stop exit by pin, edge, low supply, break or tick restarts clocks, fetches vector
// - reset or interrupt leaving stop gates clocks 4096 cycles via 12-bit counter
// - short recovery bit shrinks stop recovery gating to 32 cycles
// - reset aborts, clears fast clock bit (power-on clears all control bits), fetches reset vector, monitor high byte
// - every reset selects reference clock divided by four as bus clock
// - pin held low min pulse time resets device and sets pin flag
// - internal reset drives pin low 32 cycles, holds reset 32 more
// - power-on keeps clocks off 4096 cycles, pin at +32, fetch at +64
// - power-on sets power-on flag and clears all other flags
// - low supply drives pin while low plus 4096 plus 32 more, sets low flag
// - watchdog overflow resets and sets watchdog flag
// - any write to watchdog service location clears watchdog counter
// - bad opcode or forbidden stop resets, sets bad opcode flag
// - opcode fetch unmapped resets with bad fetch flag; data fetch does not
// - reset cause register is read-only and cleared by read
// - flags accumulate across all but power-on resets until read
// - pin sampled 32 cycles after internal release, low sets pin flag
// - monitor entry reset sets monitor entry flag
module reset_and_stop_recovery_control #(
  parameter int STAB_CYCLES = rst_seq_pkg::STAB_CYC,
  parameter int SHORT_CYCLES = rst_seq_pkg::SHORT_CYC,
  parameter int WDOG_BITS = rst_seq_pkg::WDOG_W,
  parameter int MIN_PULSE = rst_seq_pkg::MIN_PULSE_CYC
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rst_seq_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // open-drain reset pin
  input wire logic rst_pin_in,
  output logic rst_pin_out,
  output logic rst_pin_oe_n,
  // analog sources
  input wire logic por_in,
  input wire logic low_supply_in,
  // cpu events
  input wire logic bad_opcode,
  input wire logic stop_exec,
  input wire logic fetch_unmapped,
  input wire logic fetch_is_opcode,
  input wire logic monitor_entry,
  input wire logic monitor_mode,
  // stop wake sources
  input wire logic irq_fall,
  input wire logic kbd_fall,
  input wire logic break_req,
  input wire logic timebase_roll,
  // sequencer outputs
  output logic cpu_reset,
  output logic clocks_run,
  output logic bus_clk_div4,
  output logic in_stop,
  output logic osc_run_in_halt,
  output logic [15:0] vector_addr,
  output logic vector_fetch
);
  localparam int TW = rst_seq_pkg::TMR_W;

  if (STAB_CYCLES < 1 || STAB_CYCLES > (1 << TW) || SHORT_CYCLES < 1 || SHORT_CYCLES > STAB_CYCLES
      || WDOG_BITS < 2 || MIN_PULSE < 1 || MIN_PULSE > 255)
  begin : bad_param
    $error("reset_and_stop_recovery_control: parameter out of range");
  end

  // ----------------------------------------
  // reset release and input synchronisers
  // ----------------------------------------
  logic rst_q1_reg;
  logic rst_n;
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic por_q_reg;

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_q1_reg <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_q1_reg <= 1'b1;
      rst_n <= rst_q1_reg;
    end
  end

  // pin idles high through its pull-up
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_reg <= 3'h1;
      sync2_reg <= 3'h1;
      por_q_reg <= 1'b0;
    end
    else
    begin
      sync1_reg <= {low_supply_in, por_in, rst_pin_in};
      sync2_reg <= sync1_reg;
      por_q_reg <= sync2_reg[1];
    end
  end

  logic pin_s;
  logic low_s;
  logic por_evt;
  assign pin_s = sync2_reg[0];
  assign low_s = sync2_reg[2];
  assign por_evt = sync2_reg[1] && !por_q_reg;

  // ----------------------------------------
  // registers and apb decode
  // ----------------------------------------
  logic [3:0] cfg_reg;
  logic [7:0] cause_reg;
  logic [7:0] cause_next;
  logic [31:0] rdata_reg;
  logic err_reg;
  logic setup;
  logic acc_rd;
  logic acc_wr;
  logic rd_cause;
  logic wd_service;

  assign setup = psel && !penable;
  assign acc_rd = psel && penable && !pwrite;
  assign acc_wr = psel && penable && pwrite;
  assign rd_cause = acc_rd && rst_seq_pkg::addr_hit(paddr, rst_seq_pkg::CAUSE_IDX);
  assign wd_service = acc_wr && rst_seq_pkg::addr_hit(paddr, rst_seq_pkg::WDOG_IDX);
  assign pready = 1'b1;
  assign prdata = rdata_reg;
  assign pslverr = err_reg && psel && penable;

  // read data is captured in the setup cycle; only the bits captured there are cleared
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_reg <= 32'h0;
      err_reg <= 1'b0;
    end
    else if (setup)
    begin
      rdata_reg <= 32'h0;
      err_reg <= 1'b0;
      if (rst_seq_pkg::addr_hit(paddr, rst_seq_pkg::CAUSE_IDX))
        rdata_reg <= {24'h0, cause_reg};
      else if (rst_seq_pkg::addr_hit(paddr, rst_seq_pkg::CFG_IDX))
        rdata_reg <= {28'h0, cfg_reg};
      else if (!rst_seq_pkg::addr_hit(paddr, rst_seq_pkg::WDOG_IDX))
        err_reg <= 1'b1;
    end
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  rst_seq_pkg::seq_state_t state_reg;
  rst_seq_pkg::seq_state_t state_next;
  logic [WDOG_BITS-1:0] wdog_cnt_reg;
  logic [7:0] low_cnt_reg;
  logic [15:0] pend_vec_reg;
  logic from_stop_reg;
  logic ext_evt;
  logic wdog_ovf;
  logic opc_evt;
  logic fetch_evt;
  logic int_evt;
  logic restart;
  logic enter;
  logic fetch_go;
  logic pin_late;
  logic t_done;
  logic [TW-1:0] t_len;

  assign ext_evt = low_cnt_reg == 8'(MIN_PULSE) && (state_reg == rst_seq_pkg::S_RUN
                   || state_reg == rst_seq_pkg::S_STOP);
  assign wdog_ovf = state_reg == rst_seq_pkg::S_RUN && &wdog_cnt_reg;
  assign opc_evt = bad_opcode || (stop_exec && !cfg_reg[rst_seq_pkg::C_STOPOK]);
  assign fetch_evt = fetch_unmapped && fetch_is_opcode;
  assign int_evt = state_reg == rst_seq_pkg::S_RUN && (wdog_ovf || opc_evt || fetch_evt || monitor_entry);
  assign pin_late = state_reg == rst_seq_pkg::S_HOLD && t_done && !pin_s;
  assign restart = por_evt && state_reg == rst_seq_pkg::S_STAB;
  assign enter = state_next != state_reg || restart;

  always_comb
  begin
    state_next = state_reg;
    fetch_go = 1'b0;
    case (state_reg)
      rst_seq_pkg::S_RUN:
        if (ext_evt)
          state_next = rst_seq_pkg::S_EXT;
        else if (int_evt)
          state_next = rst_seq_pkg::S_PIN_LOW;
        else if (stop_exec && cfg_reg[rst_seq_pkg::C_STOPOK])
          state_next = rst_seq_pkg::S_STOP;
      rst_seq_pkg::S_STAB:
        if (t_done)
          state_next = rst_seq_pkg::S_PIN_LOW;
      rst_seq_pkg::S_LOWV:
        if (!low_s)
          state_next = rst_seq_pkg::S_STAB;
      rst_seq_pkg::S_PIN_LOW:
        if (t_done)
          state_next = rst_seq_pkg::S_HOLD;
      rst_seq_pkg::S_HOLD:
        if (t_done)
        begin
          state_next = rst_seq_pkg::S_RUN;
          fetch_go = 1'b1;
        end
      rst_seq_pkg::S_EXT:
        if (pin_s)
        begin
          state_next = from_stop_reg ? rst_seq_pkg::S_RECOV : rst_seq_pkg::S_RUN;
          fetch_go = !from_stop_reg;
        end
      rst_seq_pkg::S_STOP:
        if (ext_evt)
          state_next = rst_seq_pkg::S_EXT;
        else if (irq_fall || kbd_fall || break_req || (timebase_roll && cfg_reg[rst_seq_pkg::C_OSCRUN]))
          state_next = rst_seq_pkg::S_RECOV;
      rst_seq_pkg::S_RECOV:
        if (t_done)
        begin
          state_next = rst_seq_pkg::S_RUN;
          fetch_go = 1'b1;
        end
      default:
        state_next = rst_seq_pkg::S_STAB;
    endcase
    if (low_s && state_reg != rst_seq_pkg::S_LOWV)
    begin
      state_next = rst_seq_pkg::S_LOWV;
      fetch_go = 1'b0;
    end
    if (por_evt)
    begin
      state_next = rst_seq_pkg::S_STAB;
      fetch_go = 1'b0;
    end
  end

  // short recovery only shortens stop recovery, never the power-on delay
  always_comb
  begin
    case (state_next)
      rst_seq_pkg::S_STAB: t_len = TW'(STAB_CYCLES - 1);
      rst_seq_pkg::S_RECOV: t_len = cfg_reg[rst_seq_pkg::C_SHORT] ? TW'(SHORT_CYCLES - 1)
                                                                 : TW'(STAB_CYCLES - 1);
      rst_seq_pkg::S_PIN_LOW: t_len = TW'(rst_seq_pkg::PIN_CYC - 1);
      default: t_len = TW'(rst_seq_pkg::HOLD_CYC - 1);
    endcase
  end

  stab_timer #(
    .W(TW),
    .INIT_LEN(STAB_CYCLES)
  ) u_timer (
    .clock(clock),
    .rst_n(rst_n),
    .start(enter),
    .len_m1(t_len),
    .busy(),
    .done(t_done)
  );

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      state_reg <= rst_seq_pkg::S_STAB;
    else
      state_reg <= state_next;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      from_stop_reg <= 1'b0;
    else if (state_next == rst_seq_pkg::S_EXT && state_reg != rst_seq_pkg::S_EXT)
      from_stop_reg <= state_reg == rst_seq_pkg::S_STOP;
  end

  // external pulse width, counted only while the pin is not ours
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      low_cnt_reg <= 8'h0;
    else if (pin_s || !(state_reg == rst_seq_pkg::S_RUN || state_reg == rst_seq_pkg::S_STOP))
      low_cnt_reg <= 8'h0;
    else if (low_cnt_reg != 8'(MIN_PULSE))
      low_cnt_reg <= low_cnt_reg + 8'h1;
  end

  // counter only advances while running; stop and reset keep it cleared
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      wdog_cnt_reg <= '0;
    else if (wd_service || state_reg != rst_seq_pkg::S_RUN)
      wdog_cnt_reg <= '0;
    else
      wdog_cnt_reg <= wdog_cnt_reg + 1'b1;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      pend_vec_reg <= rst_seq_pkg::VEC_RESET;
    else if (state_reg == rst_seq_pkg::S_STOP && state_next == rst_seq_pkg::S_RECOV)
    begin
      if (irq_fall)
        pend_vec_reg <= rst_seq_pkg::VEC_IRQ;
      else if (kbd_fall)
        pend_vec_reg <= rst_seq_pkg::VEC_KBD;
      else if (break_req)
        pend_vec_reg <= rst_seq_pkg::VEC_BRK;
      else
        pend_vec_reg <= rst_seq_pkg::VEC_TBM;
    end
    else if (state_next != rst_seq_pkg::S_RUN && state_next != rst_seq_pkg::S_STOP
             && state_next != rst_seq_pkg::S_RECOV)
      pend_vec_reg <= rst_seq_pkg::VEC_RESET;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_pin_oe_n <= 1'b0;
      cpu_reset <= 1'b1;
      clocks_run <= 1'b0;
      in_stop <= 1'b0;
      vector_fetch <= 1'b0;
      vector_addr <= rst_seq_pkg::VEC_RESET;
    end
    else
    begin
      rst_pin_oe_n <= !(state_next == rst_seq_pkg::S_STAB || state_next == rst_seq_pkg::S_LOWV
                       || state_next == rst_seq_pkg::S_PIN_LOW);
      cpu_reset <= !(state_next == rst_seq_pkg::S_RUN || state_next == rst_seq_pkg::S_STOP
                    || state_next == rst_seq_pkg::S_RECOV);
      clocks_run <= !(state_next == rst_seq_pkg::S_STAB || state_next == rst_seq_pkg::S_LOWV
                     || state_next == rst_seq_pkg::S_STOP || state_next == rst_seq_pkg::S_RECOV);
      in_stop <= state_next == rst_seq_pkg::S_STOP;
      vector_fetch <= fetch_go;
      if (fetch_go)
      begin
        if (pend_vec_reg == rst_seq_pkg::VEC_RESET && monitor_mode)
          vector_addr <= rst_seq_pkg::VEC_MON;
        else
          vector_addr <= pend_vec_reg;
      end
    end
  end

  assign rst_pin_out = 1'b0;
  assign bus_clk_div4 = !cfg_reg[rst_seq_pkg::C_FAST];
  assign osc_run_in_halt = cfg_reg[rst_seq_pkg::C_OSCRUN];

  // ----------------------------------------
  // configuration and reset cause
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      cfg_reg <= rst_seq_pkg::CFG_RESET;
    else if (por_evt)
      cfg_reg <= rst_seq_pkg::CFG_RESET;
    else if (cpu_reset)
      cfg_reg[rst_seq_pkg::C_FAST] <= 1'b0;
    else if (acc_wr && rst_seq_pkg::addr_hit(paddr, rst_seq_pkg::CFG_IDX))
      cfg_reg <= pwdata[3:0];
  end

  // a flag set in the cycle of a read survives it
  always_comb
  begin
    cause_next = cause_reg & ~(rd_cause ? rdata_reg[7:0] : 8'h00);
    cause_next[rst_seq_pkg::F_PIN] = cause_next[rst_seq_pkg::F_PIN] | ext_evt | pin_late;
    cause_next[rst_seq_pkg::F_LOW] = cause_next[rst_seq_pkg::F_LOW]
                                     | (low_s && state_reg != rst_seq_pkg::S_LOWV);
    if (int_evt && !ext_evt)
    begin
      cause_next[rst_seq_pkg::F_WDOG] = cause_next[rst_seq_pkg::F_WDOG] | wdog_ovf;
      cause_next[rst_seq_pkg::F_OPC] = cause_next[rst_seq_pkg::F_OPC] | opc_evt;
      cause_next[rst_seq_pkg::F_FETCH] = cause_next[rst_seq_pkg::F_FETCH] | fetch_evt;
      cause_next[rst_seq_pkg::F_MON] = cause_next[rst_seq_pkg::F_MON] | monitor_entry;
    end
    cause_next[0] = 1'b0;
    if (por_evt)
      cause_next = rst_seq_pkg::CAUSE_RESET;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      cause_reg <= rst_seq_pkg::CAUSE_RESET;
    else
      cause_reg <= cause_next;
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic [TW:0] dwell_reg;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      dwell_reg <= '0;
    else if (enter)
      dwell_reg <= '0;
    else
      dwell_reg <= dwell_reg + 1'b1;
  end

  a_pin_low_len: assert property (@(posedge clock) disable iff (!rst_n)
    state_reg == rst_seq_pkg::S_PIN_LOW && state_next == rst_seq_pkg::S_HOLD
    |-> dwell_reg == (TW + 1)'(rst_seq_pkg::PIN_CYC - 1) && !rst_pin_oe_n ##1 rst_pin_oe_n)
    else $error("pin low time wrong");
  a_hold_fetch: assert property (@(posedge clock) disable iff (!rst_n || por_evt || low_s)
    state_reg == rst_seq_pkg::S_HOLD && $past(state_reg) == rst_seq_pkg::S_PIN_LOW
    |-> ##32 vector_fetch && !cpu_reset) else $error("hold before fetch wrong");
  a_stab_len: assert property (@(posedge clock) disable iff (!rst_n)
    state_reg == rst_seq_pkg::S_STAB && t_done && !por_evt && !low_s
    |-> dwell_reg == (TW + 1)'(STAB_CYCLES - 1) && !clocks_run) else $error("stabilization time wrong");
  a_recov_len: assert property (@(posedge clock) disable iff (!rst_n)
    state_reg == rst_seq_pkg::S_RECOV && t_done && !low_s && !por_evt
    |-> dwell_reg == (cfg_reg[rst_seq_pkg::C_SHORT] ? (TW + 1)'(SHORT_CYCLES - 1) : (TW + 1)'(STAB_CYCLES - 1))
    ##1 vector_fetch ##1 clocks_run) else $error("recovery time wrong");
  a_short_recov: assert property (@(posedge clock) disable iff (!rst_n || por_evt || low_s)
    state_reg == rst_seq_pkg::S_STOP && state_next == rst_seq_pkg::S_RECOV && cfg_reg[rst_seq_pkg::C_SHORT]
    && SHORT_CYCLES == 32 |-> ##33 vector_fetch) else $error("short recovery wrong");
  a_por_flags: assert property (@(posedge clock) disable iff (!rst_n)
    por_evt |=> cause_reg == rst_seq_pkg::CAUSE_RESET) else $error("power-on flags wrong");
  a_read_clear: assert property (@(posedge clock) disable iff (!rst_n)
    rd_cause && rdata_reg[7:0] == cause_reg && cause_next == (cause_reg & ~rdata_reg[7:0])
    |=> cause_reg == 8'h00) else $error("read did not clear");
  a_flags_stick: assert property (@(posedge clock) disable iff (!rst_n || por_evt)
    !rd_cause |=> (cause_reg & $past(cause_reg)) == $past(cause_reg)) else $error("flag lost without read");
  a_wdog_reset: assert property (@(posedge clock) disable iff (!rst_n || low_s || por_evt || ext_evt)
    wdog_ovf |=> cause_reg[rst_seq_pkg::F_WDOG] && state_reg == rst_seq_pkg::S_PIN_LOW) else $error("no watchdog reset");
  a_wdog_clear: assert property (@(posedge clock) disable iff (!rst_n)
    wd_service |=> wdog_cnt_reg == '0) else $error("watchdog not cleared");
  a_bad_stop: assert property (@(posedge clock) disable iff (!rst_n || low_s || por_evt || ext_evt)
    state_reg == rst_seq_pkg::S_RUN && stop_exec && !cfg_reg[rst_seq_pkg::C_STOPOK]
    |=> cause_reg[rst_seq_pkg::F_OPC] && cpu_reset) else $error("forbidden stop not reset");
  a_data_fetch: assert property (@(posedge clock) disable iff (!rst_n)
    state_reg == rst_seq_pkg::S_RUN && fetch_unmapped && !fetch_is_opcode && !bad_opcode && !stop_exec
    && !monitor_entry && !wdog_ovf && !ext_evt && !low_s && !por_evt |=> !cpu_reset) else $error("data fetch reset");
  a_pin_sample: assert property (@(posedge clock) disable iff (!rst_n || por_evt)
    pin_late |=> cause_reg[rst_seq_pkg::F_PIN]) else $error("late pin not flagged");
  a_bus_div4: assert property (@(posedge clock) disable iff (!rst_n)
    cpu_reset |=> bus_clk_div4) else $error("bus clock not div4 in reset");

  c_stop_wake: cover property (@(posedge clock) disable iff (!rst_n)
    state_reg == rst_seq_pkg::S_RECOV ##1 vector_fetch);
  c_ext_reset: cover property (@(posedge clock) disable iff (!rst_n) ext_evt);
  c_low_supply: cover property (@(posedge clock) disable iff (!rst_n) state_reg == rst_seq_pkg::S_LOWV);
  c_wdog: cover property (@(posedge clock) disable iff (!rst_n) wdog_ovf);

endmodule
`default_nettype wire

/* core/rst_seq_pkg.sv */
package rst_seq_pkg;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLOCK_MHZ = 250;
  // least external pulse; the figure is a plain default
  localparam int MIN_PULSE_NS = 100;
  localparam int MIN_PULSE_CYC = (MIN_PULSE_NS * CLOCK_MHZ + 999) / 1000;
  localparam int STAB_CYC = 4096;
  localparam int SHORT_CYC = 32;
  localparam int PIN_CYC = 32;
  localparam int HOLD_CYC = 32;
  localparam int TMR_W = 12;
  localparam int WDOG_W = 16;

  // ----------------------------------------
  // register map: word index, byte address is four times it
  // ----------------------------------------
  localparam int ADDR_W = 18;
  localparam logic [15:0] WDOG_IDX = 16'hFFFF;
  localparam logic [15:0] CFG_IDX = 16'hFE00;
  localparam logic [15:0] CAUSE_IDX = 16'hFE01;

  // reset_cause flag positions, bit 0 reads zero
  localparam int F_POR = 7;
  localparam int F_PIN = 6;
  localparam int F_WDOG = 5;
  localparam int F_OPC = 4;
  localparam int F_FETCH = 3;
  localparam int F_MON = 2;
  localparam int F_LOW = 1;
  localparam logic [7:0] CAUSE_RESET = 8'h80;

  // configuration bits
  localparam int C_SHORT = 0;
  localparam int C_STOPOK = 1;
  localparam int C_OSCRUN = 2;
  localparam int C_FAST = 3;
  localparam logic [3:0] CFG_RESET = 4'h0;

  // ----------------------------------------
  // vectors
  // ----------------------------------------
  localparam logic [15:0] VEC_RESET = 16'hFFFE;
  localparam logic [15:0] VEC_MON = 16'hFEFE;
  localparam logic [15:0] VEC_IRQ = 16'hFFFA;
  localparam logic [15:0] VEC_KBD = 16'hFFDE;
  localparam logic [15:0] VEC_BRK = 16'hFFFC;
  localparam logic [15:0] VEC_TBM = 16'hFFDC;

  typedef enum logic [2:0] {
    S_RUN, S_STAB, S_LOWV, S_PIN_LOW, S_HOLD, S_EXT, S_STOP, S_RECOV
  } seq_state_t;

  function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [15:0] idx);
    return a[ADDR_W-1:2] == idx && a[1:0] == 2'h0;
  endfunction

endpackage

/* core/stab_timer.sv */
`timescale 1ns/100ps
`default_nettype none
module stab_timer #(
  parameter int W = 12,
  parameter int INIT_LEN = 4096
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // control
  input wire logic start,
  input wire logic [W-1:0] len_m1,
  // status
  output logic busy,
  output logic done
);
  logic [W-1:0] cnt_reg;
  logic busy_reg;

  if (INIT_LEN < 1 || INIT_LEN > (1 << W))
  begin : bad_len
    $error("stab_timer: INIT_LEN out of range");
  end

  // ----------------------------------------
  // down counter
  // ----------------------------------------
  // out of reset it already runs the power-on delay
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_reg <= W'(INIT_LEN - 1);
      busy_reg <= 1'b1;
    end
    else if (start)
    begin
      cnt_reg <= len_m1;
      busy_reg <= 1'b1;
    end
    else if (busy_reg)
    begin
      if (cnt_reg == '0)
        busy_reg <= 1'b0;
      else
        cnt_reg <= cnt_reg - 1'b1;
    end
  end

  assign busy = busy_reg;
  assign done = busy_reg && cnt_reg == '0;

  a_done_ends: assert property (@(posedge clock) disable iff (!rst_n)
    done && !start |=> !busy) else $error("timer still busy after done");

endmodule
`default_nettype wire

/* test/reset_pin_board.sv */
`timescale 1ns/100ps
`default_nettype none
module reset_pin_board (
  // device side
  input wire logic rst_pin_out,
  input wire logic rst_pin_oe_n,
  // board side
  input wire logic pull_low,
  output logic pin_level
);
  // pull-up resistor: a released pin goes high, never keeps a stale low
  assign pin_level = (!rst_pin_oe_n && !rst_pin_out) || pull_low ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

/* test/reset_and_stop_recovery_control_test.sv */
`timescale 1ns/100ps
`default_nettype none
module reset_and_stop_recovery_control_test;
  logic clock = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, pull_low = 0;
  logic por = 0, low = 0, bad_op = 0, stop_x = 0, f_un = 0, f_op = 0, mon_e = 0, mon_m = 0;
  logic [3:0] wake = '0;
  logic [17:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, es, pin_out, oe_n, pin, cpu_reset, run, div4, in_stop, vf, osc;
  logic [15:0] vaddr;
  int error_cnt = 0, check_count = 0, n;

  always #2 clock = ~clock;

  reset_and_stop_recovery_control #(.STAB_CYCLES(64), .WDOG_BITS(9)) i_reset_and_stop_recovery_control (
    .clock, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .rst_pin_in(pin), .rst_pin_out(pin_out), .rst_pin_oe_n(oe_n), .por_in(por), .low_supply_in(low),
    .bad_opcode(bad_op), .stop_exec(stop_x), .fetch_unmapped(f_un), .fetch_is_opcode(f_op),
    .monitor_entry(mon_e), .monitor_mode(mon_m), .irq_fall(wake[0]), .kbd_fall(wake[1]),
    .break_req(wake[2]), .timebase_roll(wake[3]), .cpu_reset(cpu_reset), .clocks_run(run),
    .bus_clk_div4(div4), .in_stop(in_stop), .osc_run_in_halt(osc), .vector_addr(vaddr), .vector_fetch(vf));

  reset_pin_board i_reset_pin_board (.rst_pin_out(pin_out), .rst_pin_oe_n(oe_n), .pull_low(pull_low),
    .pin_level(pin));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic complete_run;
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1;
    pwrite <= w;
    paddr <= {idx, 2'h0};
    pwdata <= d;
    @(posedge clock);
    penable <= 1;
    do @(posedge clock); while (pready !== 1'b1 && ++k < 50);
    rd = prdata;
    es = pslverr;
    psel <= 0;
    penable <= 0;
    // one idle edge so a following call never re-drives psel in this time step
    @(posedge clock);
    if (k >= 50) error_cnt++;
    if (k >= 50) complete_run();
  endtask

  // waits for the vector fetch; n ends as the number of edges waited less one
  task automatic fetch(input logic [15:0] vec);
    n = 0;
    do @(posedge clock); while (vf !== 1'b1 && ++n < 9000);
    if (n >= 9000) error_cnt++;
    if (n >= 9000) complete_run();
    chk(vaddr, vec);
    apb(1, 16'hFFFF, 0);
  endtask

  task automatic stop_wake(input logic [3:0] cfg, input int w, input logic [15:0] vec, input int exp);
    apb(1, 16'hFE00, {28'h0, cfg});
    stop_x <= 1;
    @(posedge clock);
    stop_x <= 0;
    repeat (2) @(posedge clock);
    chk(in_stop & !run, 1);
    wake[w] <= 1;
    @(posedge clock);
    wake <= '0;
    fetch(vec);
    chk(n, exp);
  endtask

  task automatic cause(input logic [7:0] exp);
    apb(0, 16'hFE01, 0);
    chk(rd, {24'h0, exp});
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial
  begin
    repeat (8) @(posedge clock);
    resetn <= 1;
    fetch(16'hFFFE);
    chk(div4, 1);
    cause(8'h80);
    cause(8'h00);
    apb(1, 16'hFE01, 32'hFF);
    cause(8'h00);
    apb(0, 16'h1234, 0);
    chk(es, 1);
    // short and full recovery, every wake source
    stop_wake(4'h3, 0, 16'hFFFA, 32);
    stop_wake(4'h2, 1, 16'hFFDE, 64);
    stop_wake(4'h2, 2, 16'hFFFC, 64);
    stop_wake(4'hE, 3, 16'hFFDC, 64);
    chk(osc, 1);
    chk(div4, 0);
    cause(8'h00);
    bad_op <= 1;
    @(posedge clock);
    bad_op <= 0;
    // board keeps the pin low past the internal release
    pull_low <= 1;
    fetch(16'hFFFE);
    pull_low <= 0;
    chk(n, 64);
    chk(div4, 1);
    cause(8'h50);
    // a data fetch from an unmapped place must not reset
    f_un <= 1;
    @(posedge clock);
    f_un <= 0;
    repeat (3) @(posedge clock);
    chk(cpu_reset, 0);
    f_un <= 1;
    f_op <= 1;
    @(posedge clock);
    f_un <= 0;
    f_op <= 0;
    fetch(16'hFFFE);
    apb(1, 16'hFE00, 0);
    stop_x <= 1;
    @(posedge clock);
    stop_x <= 0;
    fetch(16'hFFFE);
    cause(8'h18);
    // watchdog left unserviced
    n = 0;
    fetch(16'hFFFE);
    cause(8'h20);
    mon_m <= 1;
    mon_e <= 1;
    @(posedge clock);
    mon_e <= 0;
    fetch(16'hFEFE);
    mon_m <= 0;
    cause(8'h04);
    low <= 1;
    repeat (20) @(posedge clock);
    low <= 0;
    fetch(16'hFFFE);
    cause(8'h02);
    pull_low <= 1;
    repeat (40) @(posedge clock);
    pull_low <= 0;
    fetch(16'hFFFE);
    cause(8'h40);
    por <= 1;
    @(posedge clock);
    por <= 0;
    fetch(16'hFFFE);
    cause(8'h80);
    complete_run();
  end
endmodule
`default_nettype wire
